//--- design/dpj_panel.sv
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dpj_panel
   import dpj_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire dpj_pkg::dpj_keys_t keys,
   input wire logic drive_enabled,
   input wire logic [8:0] discrete_inputs_1_to_9,
   input wire logic [5:0] normal_do_request,
   output logic [5:0] discrete_outputs_1_to_6,
   output logic jog_run,
   output logic jog_dir_cw,
   output logic [15:0] jog_speed_cmd,
   output dpj_pkg::dpj_disp_t disp
);
   import dpj_pkg::*;

   logic set_press;
   logic up_press;
   logic down_press;
   logic mode_press;
   logic up_held;
   logic down_held;

   dpj_key_edge u_key_set
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .key_lvl(keys.set),
      .held(),
      .press(set_press)
   );
   dpj_key_edge u_key_up
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .key_lvl(keys.up),
      .held(up_held),
      .press(up_press)
   );
   dpj_key_edge u_key_down
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .key_lvl(keys.down),
      .held(down_held),
      .press(down_press)
   );
   dpj_key_edge u_key_mode
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .key_lvl(keys.mode),
      .held(),
      .press(mode_press)
   );

   dpj_state_t state_r;
   dpj_state_t state_nxt;
   logic [3:0] panel_sel_r;
   logic [15:0] jog_speed_r;
   logic [11:0] diag_code_r;
   logic force_on_r;
   logic [15:0] force_val_r;
   logic [15:0] hist_r [0:N_HIST-1];
   logic [2:0] hist_idx_r;
   logic [8:0] di_vec_r;
   logic [5:0] do_r;
   logic jog_run_r;
   logic jog_dir_r;
   dpj_disp_t disp_r;
   dpj_disp_t disp_nxt;

   // AXI4-Lite write side: address and data taken in either order
   logic aw_have_r;
   logic w_have_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic wr_go;
   logic wr_hit;
   logic [31:0] wmask;

   assign s_axi_awready = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready = ~w_have_r & ~bvalid_r;
   assign wr_go = aw_have_r & w_have_r & ~bvalid_r;
   assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_have_r <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         else if (wr_go)
            w_have_r <= 1'b0;
      end
   end

   always_comb
   begin
      wr_hit = 1'b0;
      case (aw_addr_r)
         OFS_PANEL_SEL, OFS_JOG_SPEED, OFS_DIAG_MODE, OFS_FORCE_VAL,
         OFS_STATUS, OFS_DI_DIAG, OFS_DO_DIAG: wr_hit = 1'b1;
         default: wr_hit = (aw_addr_r >= OFS_HIST_FIRST) && (aw_addr_r <= OFS_HIST_LAST)
                           && (aw_addr_r[1:0] == 2'h0);
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   function automatic logic wr_to(input logic [7:0] ofs);
      wr_to = wr_go && (aw_addr_r == ofs);
   endfunction

   // Register writes; read-only registers simply ignore data
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         panel_sel_r <= SEL_NONE;
      else if (wr_to(OFS_PANEL_SEL) && w_strb_r[0])
         panel_sel_r <= w_data_r[3:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         force_val_r <= 16'h0000;
      else if (wr_to(OFS_FORCE_VAL))
         force_val_r <= (force_val_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         for (int i = 0; i < N_HIST; i++)
            hist_r[i] <= 16'h0000;
      else if (wr_go && wr_hit && (aw_addr_r >= OFS_HIST_FIRST) && (aw_addr_r <= OFS_HIST_LAST))
         hist_r[aw_addr_r[4:2] - 3'h4] <=
            (hist_r[aw_addr_r[4:2] - 3'h4] & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
   end

   // Diagnostic code is volatile; only the two defined codes act
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         diag_code_r <= 12'h000;
         force_on_r <= 1'b0;
      end
      else if (wr_to(OFS_DIAG_MODE) && (w_strb_r[1:0] == 2'h3))
      begin
         diag_code_r <= w_data_r[11:0];
         if (w_data_r[11:0] == DIAG_FORCE_ON)
            force_on_r <= 1'b1;
         else if (w_data_r[11:0] == DIAG_FORCE_OFF)
            force_on_r <= 1'b0;
      end
   end

   // Output drive and live diagnostic vectors
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         do_r <= 6'h00;
         di_vec_r <= 9'h000;
      end
      else
      begin
         do_r <= force_on_r ? force_val_r[5:0] : normal_do_request;
         di_vec_r <= discrete_inputs_1_to_9;
      end
   end

   assign discrete_outputs_1_to_6 = do_r;

   // Panel state machine
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_BROWSE:
            if (set_press)
            begin
               if (panel_sel_r >= SEL_HIST_FIRST && panel_sel_r <= SEL_HIST_LAST)
                  state_nxt = ST_HIST;
               else if (panel_sel_r == SEL_JOG)
                  state_nxt = ST_JOG_SPD;
               else if (panel_sel_r == SEL_DI)
                  state_nxt = ST_DI;
               else if (panel_sel_r == SEL_DO)
                  state_nxt = ST_DO;
               else if (panel_sel_r == SEL_FORCE)
                  state_nxt = ST_FORCE;
               else
                  state_nxt = ST_BROWSE;
            end
         ST_JOG_SPD:
            if (mode_press)
               state_nxt = ST_BROWSE;
            else if (set_press)
               state_nxt = ST_JOG_RUN;
         ST_JOG_RUN:
            if (mode_press)
               state_nxt = ST_BROWSE;
         ST_HIST, ST_DI, ST_DO, ST_FORCE:
            if (mode_press)
               state_nxt = ST_BROWSE;
         default: state_nxt = ST_BROWSE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         state_r <= ST_BROWSE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         hist_idx_r <= 3'h0;
      else if (state_r == ST_BROWSE && set_press)
         hist_idx_r <= 3'(panel_sel_r - SEL_HIST_FIRST);
   end

   // Key edits saturate; a software write in the same cycle wins
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         jog_speed_r <= JOG_SPEED_DEFAULT;
      else if (wr_to(OFS_JOG_SPEED))
         jog_speed_r <= (jog_speed_r & ~wmask[15:0]) | (w_data_r[15:0] & wmask[15:0]);
      else if (state_r == ST_JOG_SPD && up_press && jog_speed_r < JOG_SPEED_MAX)
         jog_speed_r <= jog_speed_r + JOG_SPEED_STEP;
      else if (state_r == ST_JOG_SPD && down_press && jog_speed_r != 16'h0000)
         jog_speed_r <= jog_speed_r - JOG_SPEED_STEP;
   end

   // Both keys held together is treated as no command
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         jog_run_r <= 1'b0;
         jog_dir_r <= 1'b0;
      end
      else
      begin
         jog_run_r <= (state_r == ST_JOG_RUN) && !mode_press && drive_enabled
                      && (up_held ^ down_held);
         jog_dir_r <= up_held;
      end
   end

   assign jog_run = jog_run_r;
   assign jog_dir_cw = jog_dir_r;
   assign jog_speed_cmd = jog_speed_r;

   // Display contents
   always_comb
   begin
      disp_nxt.value = 20'h00000;
      disp_nxt.blank = BLANK_NONE;
      disp_nxt.hex = 1'b0;
      disp_nxt.jog_text = 1'b0;
      case (state_r)
         ST_BROWSE: disp_nxt.value = {16'h0000, panel_sel_r};
         ST_HIST:
         begin
            disp_nxt.value = {4'h0, hist_r[hist_idx_r]};
            disp_nxt.hex = 1'b1;
         end
         ST_JOG_SPD: disp_nxt.value = {4'h0, jog_speed_r};
         ST_JOG_RUN: disp_nxt.jog_text = 1'b1;
         ST_DI:
         begin
            disp_nxt.value = {11'h000, di_vec_r};
            disp_nxt.blank = BLANK_DI;
            disp_nxt.hex = 1'b1;
         end
         ST_DO:
         begin
            disp_nxt.value = {14'h0000, do_r};
            disp_nxt.blank = BLANK_DO;
            disp_nxt.hex = 1'b1;
         end
         ST_FORCE:
         begin
            disp_nxt.value = {4'h0, force_val_r};
            disp_nxt.blank = BLANK_FIFTH;
            disp_nxt.hex = 1'b1;
         end
         default: disp_nxt.value = 20'h00000;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         disp_r <= '0;
      else
         disp_r <= disp_nxt;
   end

   assign disp = disp_r;

   // AXI4-Lite read side, one cycle from address to data
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [31:0] rd_word;
   logic rd_hit;

   assign s_axi_arready = ~rvalid_r;

   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         OFS_PANEL_SEL: rd_word = {28'h0000000, panel_sel_r};
         OFS_JOG_SPEED: rd_word = {16'h0000, jog_speed_r};
         OFS_DIAG_MODE: rd_word = {15'h0000, force_on_r, 4'h0, diag_code_r};
         OFS_FORCE_VAL: rd_word = {16'h0000, force_val_r};
         OFS_STATUS: rd_word = {20'h00000, jog_dir_r, jog_run_r, force_on_r,
                                drive_enabled, 1'b0, state_r};
         OFS_DI_DIAG: rd_word = {23'h000000, di_vec_r};
         OFS_DO_DIAG: rd_word = {26'h0000000, do_r};
         default:
         begin
            rd_hit = (s_axi_araddr >= OFS_HIST_FIRST) && (s_axi_araddr <= OFS_HIST_LAST)
                     && (s_axi_araddr[1:0] == 2'h0);
            if (rd_hit)
               rd_word = {16'h0000, hist_r[s_axi_araddr[4:2] - 3'h4]};
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

//--- design/dpj_pkg.sv
package dpj_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] OFS_PANEL_SEL = 8'h00;
   localparam logic [7:0] OFS_JOG_SPEED = 8'h04;
   localparam logic [7:0] OFS_DIAG_MODE = 8'h08;
   localparam logic [7:0] OFS_FORCE_VAL = 8'h0C;
   localparam logic [7:0] OFS_HIST_FIRST = 8'h10;
   localparam logic [7:0] OFS_HIST_LAST = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_DI_DIAG = 8'h28;
   localparam logic [7:0] OFS_DO_DIAG = 8'h2C;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   // Panel parameter selection codes
   localparam logic [3:0] SEL_NONE = 4'h0;
   localparam logic [3:0] SEL_HIST_FIRST = 4'h1;
   localparam logic [3:0] SEL_HIST_LAST = 4'h5;
   localparam logic [3:0] SEL_JOG = 4'h6;
   localparam logic [3:0] SEL_DI = 4'h7;
   localparam logic [3:0] SEL_DO = 4'h8;
   localparam logic [3:0] SEL_FORCE = 4'h9;

   localparam int N_HIST = 5;
   localparam int N_DI = 9;
   localparam int N_DO = 6;

   localparam logic [15:0] JOG_SPEED_DEFAULT = 16'h0014;
   localparam logic [15:0] JOG_SPEED_MAX = 16'h1388;
   localparam logic [15:0] JOG_SPEED_STEP = 16'h0001;

   localparam logic [11:0] DIAG_FORCE_ON = 12'h006;
   localparam logic [11:0] DIAG_FORCE_OFF = 12'h106;

   // Blank masks, bit i blanks display digit i (digit 0 rightmost)
   localparam logic [4:0] BLANK_NONE = 5'h00;
   localparam logic [4:0] BLANK_DI = 5'h18;
   localparam logic [4:0] BLANK_DO = 5'h1C;
   localparam logic [4:0] BLANK_FIFTH = 5'h10;

   typedef struct packed {
      logic set;
      logic up;
      logic down;
      logic mode;
   } dpj_keys_t;

   typedef struct packed {
      logic [19:0] value;
      logic [4:0] blank;
      logic hex;
      logic jog_text;
   } dpj_disp_t;

   typedef enum logic [6:0] {
      ST_BROWSE = 7'h01,
      ST_HIST = 7'h02,
      ST_JOG_SPD = 7'h04,
      ST_JOG_RUN = 7'h08,
      ST_DI = 7'h10,
      ST_DO = 7'h20,
      ST_FORCE = 7'h40
   } dpj_state_t;

endpackage

//--- design/dpj_key_edge.sv
`timescale 1ns/1ps
`default_nettype none
module dpj_key_edge
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic key_lvl,
   output logic held,
   output logic press
);
   logic lvl_r;
   logic prev_r;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         lvl_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         lvl_r <= key_lvl;
         prev_r <= lvl_r;
      end
   end

   assign held = lvl_r;
   // One pulse per press, so a held key never repeats
   assign press = lvl_r & ~prev_r;
endmodule
`default_nettype wire

//--- bench/dpj_keypad_model.sv
`timescale 1ns/1ps
`default_nettype none
// Operator keypad: levels change just after an edge, one edge late when slow
module dpj_keypad_model
   import dpj_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [3:0] want,
   input wire logic slow,
   output dpj_pkg::dpj_keys_t keys
);
   logic [3:0] late_r;
   always_ff @(posedge sys_clk)
   begin
      late_r <= want;
      keys <= slow ? late_r : want;
   end
endmodule
`default_nettype wire

//--- bench/dpj_panel_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dpj_panel_asserts
   import dpj_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic s_axi_bvalid,
   input wire dpj_pkg::dpj_keys_t keys,
   input wire logic drive_enabled,
   input wire logic [5:0] discrete_outputs_1_to_6,
   input wire logic jog_run,
   input wire logic jog_dir_cw,
   input wire logic [15:0] jog_speed_cmd,
   input wire dpj_pkg::dpj_disp_t disp
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Four samples cover the two-cycle key-to-motion latency (key register, then jog register)
   sequence s_up_held;
      (keys.up && !keys.down) [*4];
   endsequence
   sequence s_dn_held;
      (keys.down && !keys.up) [*4];
   endsequence
   sequence s_idle;
      (!keys.up && !keys.down) [*4];
   endsequence
   a_reset_state: assert property ($fell(rst) |-> jog_speed_cmd == JOG_SPEED_DEFAULT
      && !jog_run && disp == '0 && discrete_outputs_1_to_6 == '0)
      else $error("state after reset wrong");
   a_up_cw: assert property (s_up_held ##0 jog_run |-> jog_dir_cw)
      else $error("up key gave wrong direction");
   a_down_ccw: assert property (s_dn_held ##0 jog_run |-> !jog_dir_cw)
      else $error("down key gave wrong direction");
   a_release_stop: assert property (s_idle |-> !jog_run)
      else $error("jog runs with no key held");
   a_needs_enable: assert property (jog_run |-> $past(drive_enabled))
      else $error("jog runs while drive disabled");
   a_mode_exit: assert property ($rose(keys.mode) |-> ##[1:3] !jog_run)
      else $error("mode key did not stop jog");
   a_jog_text: assert property (jog_run |-> disp.jog_text)
      else $error("jog runs without jog text");
   a_speed_kept: assert property (jog_run ##1 !$rose(s_axi_bvalid) |-> $stable(jog_speed_cmd))
      else $error("jog speed changed while running");
   a_di_hex: assert property (disp.blank == BLANK_DI |-> disp.hex && disp.value[19:9] == '0)
      else $error("input view not nine-bit hex");
   a_do_hex: assert property (disp.blank == BLANK_DO |-> disp.hex && disp.value[19:6] == '0)
      else $error("output view not six-bit hex");
endmodule
bind dpj_panel dpj_panel_asserts chk (.sys_clk(sys_clk), .rst(rst), .s_axi_bvalid(s_axi_bvalid),
   .keys(keys), .drive_enabled(drive_enabled), .discrete_outputs_1_to_6(discrete_outputs_1_to_6),
   .jog_run(jog_run), .jog_dir_cw(jog_dir_cw), .jog_speed_cmd(jog_speed_cmd), .disp(disp));
`default_nettype wire

//--- bench/dpj_panel_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dpj_panel_bench;
   import dpj_pkg::*;
   logic sys_clk, rst, slow, den, awv, wv, arv, awr, wr_r, bv, arr, rv;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, got;
   logic [1:0] br, rr, resp;
   logic [3:0] want;
   logic [8:0] di;
   logic [5:0] ndo, dout, v;
   logic jr, jcw;
   logic [15:0] spd, jsc;
   logic [15:0] code [N_HIST];
   dpj_keys_t keys;
   dpj_disp_t disp;
   int miscompares = 0, n_tests = 0, cyc = 0, n, seed;
   dpj_keypad_model PAD (.sys_clk(sys_clk), .want(want), .slow(slow), .keys(keys));
   dpj_panel DUT (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(1'h1), .keys(keys), .drive_enabled(den), .discrete_inputs_1_to_9(di),
      .normal_do_request(ndo), .discrete_outputs_1_to_6(dout), .jog_run(jr),
      .jog_dir_cw(jcw), .jog_speed_cmd(jsc), .disp(disp));
   function automatic logic [5:0] exp_do(input logic f, input logic [5:0] fv, input logic [5:0] nd);
      return f ? fv : nd;
   endfunction
   task end_sim;
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e)
      begin
         $display("BAD %0t got %h exp %h", $time, g, e);
         miscompares++;
      end
   endtask
   // Handshakes are judged at the falling edge, where they hold until the next rising edge
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ao, wo, bo;
      @(posedge sys_clk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bo = 1'h0;
      while (!bo)
      begin
         @(negedge sys_clk);
         ao = awv && awr;
         wo = wv && wr_r;
         bo = bv;
         resp = br;
         @(posedge sys_clk);
         if (ao) awv <= 1'h0;
         if (wo) wv <= 1'h0;
      end
   endtask
   task rd(input logic [7:0] a);
      logic ro, go;
      @(posedge sys_clk);
      ara <= a;
      arv <= 1'h1;
      go = 1'h0;
      while (!go)
      begin
         @(negedge sys_clk);
         ro = arv && arr;
         go = rv;
         got = rdat;
         resp = rr;
         @(posedge sys_clk);
         if (ro) arv <= 1'h0;
      end
   endtask
   task wt(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task press(input logic [3:0] k);
      @(posedge sys_clk);
      want <= k;
      repeat (4) @(posedge sys_clk);
      want <= 4'h0;
      wt(5);
   endtask
   task hold(input logic [3:0] k, input logic e, input int t);
      @(posedge sys_clk);
      want <= k;
      den <= e;
      wt(t);
   endtask
   initial
   begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         miscompares++;
         end_sim;
      end
   end
   initial
   begin
      seed = 32'h05380E21;
      {rst, slow, den, awv, wv, arv, awa, ara, wd, want, di, ndo} = '0;
      rst = 1'h1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      wt(0);
      chk(jsc, JOG_SPEED_DEFAULT);
      rd(8'h40);
      chk(resp, RESP_DECERR);
      wr(8'h40, 32'h0000_0000);
      chk(resp, RESP_DECERR);
      for (int i = 0; i < N_HIST; i++)
      begin
         code[i] = 16'($random(seed));
         wr(OFS_HIST_FIRST + 8'(4 * i), {16'h0, code[i]});
      end
      chk(resp, RESP_OKAY);
      for (int i = 0; i < N_HIST; i++)
      begin
         @(posedge sys_clk);
         slow <= i[0];
         wr(OFS_PANEL_SEL, 32'(SEL_HIST_FIRST + 4'(i)));
         press(4'h8);
         chk(disp.value, code[i]);
         press(4'h1);
      end
      @(posedge sys_clk);
      slow <= 1'h0;
      wr(OFS_PANEL_SEL, 32'(SEL_JOG));
      press(4'h8);
      chk(disp.value, JOG_SPEED_DEFAULT);
      n = 2 + ($random(seed) & 3);
      repeat (n) press(4'h4);
      press(4'h2);
      spd = JOG_SPEED_DEFAULT + 16'(n) - JOG_SPEED_STEP;
      chk(jsc, spd);
      press(4'h8);
      chk(disp.jog_text, 1'h1);
      hold(4'h4, 1'h1, 6);
      chk({jr, jcw}, 2'h3);
      hold(4'h0, 1'h1, 3);
      chk(jr, 1'h0);
      hold(4'h2, 1'h1, 6);
      chk({jr, jcw}, 2'h2);
      hold(4'h2, 1'h0, 3);
      chk(jr, 1'h0);
      chk(jsc, spd);
      hold(4'h4, 1'h1, 6);
      hold(4'h5, 1'h1, 4);
      chk({jr, disp.jog_text}, 2'h0);
      hold(4'h0, 1'h1, 3);
      for (int j = 0; j < 4; j++)
      begin
         v = (j == 0) ? 6'h05 : 6'($random(seed));
         @(posedge sys_clk);
         ndo <= ~v;
         wr(OFS_DIAG_MODE, 32'(DIAG_FORCE_ON));
         wr(OFS_FORCE_VAL, 32'(v));
         wt(2);
         chk(dout, exp_do(1'h1, v, ~v));
         rd(OFS_DO_DIAG);
         chk(got, 32'(v));
         wr(OFS_PANEL_SEL, 32'(SEL_FORCE));
         press(4'h8);
         chk({disp.value, disp.blank[4], disp.hex}, {20'(v), 2'h3});
         press(4'h1);
         wr(OFS_DIAG_MODE, 32'(DIAG_FORCE_OFF));
         wt(2);
         chk(dout, exp_do(1'h0, v, ~v));
      end
      // A second reset stands in for a power cycle while forcing
      wr(OFS_DIAG_MODE, 32'(DIAG_FORCE_ON));
      @(posedge sys_clk);
      rst <= 1'h1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      rd(OFS_DIAG_MODE);
      chk(got[16], 1'h0);
      wr(OFS_PANEL_SEL, 32'(SEL_DI));
      press(4'h8);
      for (int j = 0; j < 6; j++)
      begin
         @(posedge sys_clk);
         di <= (j == 0) ? 9'h1A1 : 9'($random(seed));
         ndo <= 6'($random(seed));
         wt(3);
         chk(disp.value, 32'(di));
         rd(OFS_DI_DIAG);
         chk(got, 32'(di));
      end
      press(4'h1);
      wr(OFS_PANEL_SEL, 32'(SEL_DO));
      press(4'h8);
      chk(disp.value, 32'(ndo));
      end_sim;
   end
endmodule
`default_nettype wire
